// ### design/asp_map.svh
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// Register indices; byte address is four times the index
`define ASP_CTRL_IDX 10'h098
`define ASP_DATA_IDX 10'h099
`define ASP_CTRL_RESET 8'h40
`define ASP_DATA_RESET 8'h00
// Control register field positions
`define ASP_BIT_MODE 7
`define ASP_BIT_UNUSED 6
`define ASP_BIT_MCE 5
`define ASP_BIT_REN 4
`define ASP_BIT_TB8 3
`define ASP_BIT_RB8 2
`define ASP_BIT_TI 1
`define ASP_BIT_RI 0
// Frame shape
`define ASP_DATA_BITS 4'h8
`define ASP_LAST_DATA 4'h7
`endif

// ### design/asp_pkg.sv
package asp_pkg;
   typedef enum logic [2:0] {
      ASP_IDLE = 3'b000,
      ASP_START = 3'b001,
      ASP_DATA = 3'b010,
      ASP_NINTH = 3'b011,
      ASP_STOP = 3'b100
   } asp_state_t;

   typedef struct packed {
      logic mode9;
      logic mce;
      logic ren;
      logic tb8;
      logic rb8;
      logic ti;
      logic ri;
   } asp_ctrl_t;

   typedef struct packed {
      logic nine;
      logic ninth;
      logic [7:0] data;
   } asp_tx_req_t;
endpackage

// ### design/asp_baud_timer.sv
`timescale 1ns/1ps
module asp_baud_timer #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic run,
   input wire logic tick,
   input wire logic restart,
   input wire logic [W-1:0] reload,
   output logic half_tick,
   output logic bit_tick
);
   import asp_pkg::*;
   logic [W-1:0] cnt_r, cnt_nxt;
   logic phase_r, phase_nxt;
   logic ovf;

   assign ovf = run & tick & (cnt_r == {W{1'b1}}) & ~restart;
   // Odd overflows mark mid-bit, even ones bit boundaries: overflow rate / 2
   assign half_tick = ovf & ~phase_r;
   assign bit_tick = ovf & phase_r;

   always_comb begin
      cnt_nxt = cnt_r;
      phase_nxt = phase_r;
      if (restart) begin
         cnt_nxt = reload;
         phase_nxt = 1'b0;
      end else if (ovf) begin
         cnt_nxt = reload;
         phase_nxt = ~phase_r;
      end else if (run & tick) begin
         cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         phase_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
      end
   end
endmodule // asp_baud_timer

// ### design/asp_tx.sv
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_tx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic start,
   input wire asp_pkg::asp_tx_req_t req,
   input wire logic bit_tick,
   output logic serial_out_pin,
   output logic done,
   output logic busy
);
   import asp_pkg::*;
   asp_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic nine_r, nine_nxt;
   logic ninth_r, ninth_nxt;
   logic out_r, out_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      nine_nxt = nine_r;
      ninth_nxt = ninth_r;
      done = 1'b0;
      if (start) begin
         // A new write restarts the frame at once
         state_nxt = ASP_START;
         shift_nxt = req.data;
         nine_nxt = req.nine;
         ninth_nxt = req.ninth;
         cnt_nxt = 4'h0;
      end else if (bit_tick) begin
         case (state_r)
            ASP_START: begin
               state_nxt = ASP_DATA;
            end
            ASP_DATA: begin
               if (cnt_r == `ASP_LAST_DATA) begin
                  state_nxt = nine_r ? ASP_NINTH : ASP_STOP;
                  done = ~nine_r;
               end else begin
                  shift_nxt = {1'b0, shift_r[7:1]};
                  cnt_nxt = cnt_r + 4'h1;
               end
            end
            ASP_NINTH: begin
               state_nxt = ASP_STOP;
               done = 1'b1;
            end
            ASP_STOP: begin
               state_nxt = ASP_IDLE;
            end
            default: begin
               state_nxt = ASP_IDLE;
            end
         endcase
      end
      case (state_nxt)
         ASP_START: out_nxt = 1'b0;
         ASP_DATA: out_nxt = shift_nxt[0];
         ASP_NINTH: out_nxt = ninth_nxt;
         default: out_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ASP_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         nine_r <= 1'b0;
         ninth_r <= 1'b0;
         out_r <= 1'b1;
      end else if (ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         nine_r <= nine_nxt;
         ninth_r <= ninth_nxt;
         out_r <= out_nxt;
      end
   end

   assign serial_out_pin = out_r;
   assign busy = (state_r != ASP_IDLE);

   property p_tx_ninth_bit;
      @(posedge pclk) disable iff (!presetn)
      (ce && bit_tick && !start && state_r == ASP_DATA && cnt_r == `ASP_LAST_DATA && nine_r)
         |=> (serial_out_pin == ninth_r) && !done;
   endproperty
   a_tx_ninth_bit: assert property (p_tx_ninth_bit)
      else $error("ninth bit not driven after eighth data bit");
endmodule // asp_tx

// ### design/asp_uart.sv
// What this block does
// - Control bit 7 low picks 8-bit frames, high picks 9-bit frames.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 8-bit accepted frame stores data and copies stop bit to ninth-receive bit.
// - Writing the data buffer starts transmitting that byte.
// - Transmit-done flag sets when the last data bit (9-bit: the ninth bit) ends, at stop-bit start.
// - Receiver takes frames only while receive-enable bit is set.
// - 8-bit load needs receive-done clear and, with check on, stop high.
// - Failed load leaves buffer, ninth bit and receive-done untouched.
// - On overrun the first unread byte stays; later frames are dropped.
// - 9-bit frame adds ninth-transmit bit after data, before stop.
// - 9-bit accepted frame stores ninth bit; stop level is ignored.
// - 9-bit load needs receive-done clear and, with filter on, ninth high.
// - Receive-done sets at stop-bit sampling of an accepted frame.
// - Interrupt request, when enabled, follows either done flag.
// - Done flags are cleared only by software writes.
// - Control bit 6 reads one and ignores writes.
// - Bit rate is half the baud timer overflow rate.
// - Start edge on the input reloads the private receive timer.
// - Data reads return received byte; writes reach only transmit side.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_uart #(
   parameter int TW = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic baud_run,
   input wire logic baud_tick,
   input wire logic [TW-1:0] baud_reload_value,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   input wire logic irq_enable,
   output logic irq
);
   import asp_pkg::*;
   asp_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] rx_buf_r, rx_buf_nxt;
   asp_state_t rx_state_r, rx_state_nxt;
   logic [3:0] rx_cnt_r, rx_cnt_nxt;
   logic [7:0] rx_shift_r, rx_shift_nxt;
   logic rx_ninth_r, rx_ninth_nxt;
   logic rx_prev_r;
   logic acc, wr, rd_ctrl, rd_data, sel_ctrl, sel_data;
   logic wr_ctrl, wr_data;
   logic [7:0] ctrl_byte;
   logic rx_start, rx_half, tx_bit, tx_done;
   logic rx_stop_hit, rx_accept, filter_ok;
   asp_tx_req_t tx_req;

   // APB slave: zero wait states, error on unmapped addresses
   assign acc = psel & penable;
   assign sel_ctrl = (paddr[11:2] == `ASP_CTRL_IDX);
   assign sel_data = (paddr[11:2] == `ASP_DATA_IDX);
   assign wr = acc & pwrite;
   assign wr_ctrl = wr & sel_ctrl;
   assign wr_data = wr & sel_data;
   assign rd_ctrl = acc & ~pwrite & sel_ctrl;
   assign rd_data = acc & ~pwrite & sel_data;
   assign pready = 1'b1;
   assign pslverr = acc & ~(sel_ctrl | sel_data);

   assign ctrl_byte = {ctrl_r.mode9, 1'b1, ctrl_r.mce, ctrl_r.ren,
                       ctrl_r.tb8, ctrl_r.rb8, ctrl_r.ti, ctrl_r.ri};

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_ctrl) begin
         prdata = {24'h00_0000, ctrl_byte};
      end else if (rd_data) begin
         // Transmit register is write only
         prdata = {24'h00_0000, rx_buf_r};
      end
   end

   asp_baud_timer #(.W(TW)) u_tx_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .run(baud_run),
      .tick(baud_tick),
      .restart(wr_data),
      .reload(baud_reload_value),
      .half_tick(),
      .bit_tick(tx_bit)
   );

   asp_baud_timer #(.W(TW)) u_rx_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .run(baud_run),
      .tick(baud_tick),
      .restart(rx_start),
      .reload(baud_reload_value),
      .half_tick(rx_half),
      .bit_tick()
   );

   assign tx_req = '{nine: ctrl_r.mode9, ninth: ctrl_r.tb8, data: pwdata[7:0]};

   asp_tx u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(wr_data),
      .req(tx_req),
      .bit_tick(tx_bit),
      .serial_out_pin(serial_out_pin),
      .done(tx_done),
      .busy()
   );

   // Receiver
   assign rx_start = (rx_state_r == ASP_IDLE) & ctrl_r.ren & rx_prev_r & ~serial_in_pin;
   assign rx_stop_hit = (rx_state_r == ASP_STOP) & rx_half & ctrl_r.ren;
   // The filter looks at stop in 8-bit mode and the ninth bit in 9-bit mode
   assign filter_ok = ~ctrl_r.mce | (ctrl_r.mode9 ? rx_ninth_r : serial_in_pin);
   assign rx_accept = rx_stop_hit & ~ctrl_r.ri & filter_ok;

   always_comb begin
      rx_state_nxt = rx_state_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_shift_nxt = rx_shift_r;
      rx_ninth_nxt = rx_ninth_r;
      if (!ctrl_r.ren) begin
         rx_state_nxt = ASP_IDLE;
      end else if (rx_start) begin
         rx_state_nxt = ASP_START;
         rx_cnt_nxt = 4'h0;
      end else if (rx_half) begin
         case (rx_state_r)
            ASP_START: begin
               // A glitch shorter than half a bit is not a start
               rx_state_nxt = serial_in_pin ? ASP_IDLE : ASP_DATA;
            end
            ASP_DATA: begin
               rx_shift_nxt = {serial_in_pin, rx_shift_r[7:1]};
               rx_cnt_nxt = rx_cnt_r + 4'h1;
               if (rx_cnt_r == `ASP_LAST_DATA) begin
                  rx_state_nxt = ctrl_r.mode9 ? ASP_NINTH : ASP_STOP;
               end
            end
            ASP_NINTH: begin
               rx_ninth_nxt = serial_in_pin;
               rx_state_nxt = ASP_STOP;
            end
            ASP_STOP: begin
               rx_state_nxt = ASP_IDLE;
            end
            default: begin
               rx_state_nxt = ASP_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      rx_buf_nxt = rx_buf_r;
      if (wr_ctrl) begin
         ctrl_nxt.mode9 = pwdata[`ASP_BIT_MODE];
         ctrl_nxt.mce = pwdata[`ASP_BIT_MCE];
         ctrl_nxt.ren = pwdata[`ASP_BIT_REN];
         ctrl_nxt.tb8 = pwdata[`ASP_BIT_TB8];
         ctrl_nxt.rb8 = pwdata[`ASP_BIT_RB8];
         ctrl_nxt.ti = pwdata[`ASP_BIT_TI];
         ctrl_nxt.ri = pwdata[`ASP_BIT_RI];
      end
      // Hardware sets after the software write so a set is never lost
      if (tx_done) begin
         ctrl_nxt.ti = 1'b1;
      end
      if (rx_accept) begin
         rx_buf_nxt = rx_shift_r;
         ctrl_nxt.rb8 = ctrl_r.mode9 ? rx_ninth_r : serial_in_pin;
         ctrl_nxt.ri = 1'b1;
      end
   end

   assign irq = irq_enable & (ctrl_r.ti | ctrl_r.ri);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '0;
         rx_buf_r <= `ASP_DATA_RESET;
         rx_state_r <= ASP_IDLE;
         rx_cnt_r <= 4'h0;
         rx_shift_r <= 8'h00;
         rx_ninth_r <= 1'b0;
         rx_prev_r <= 1'b1;
      end else if (ce) begin
         ctrl_r <= ctrl_nxt;
         rx_buf_r <= rx_buf_nxt;
         rx_state_r <= rx_state_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_shift_r <= rx_shift_nxt;
         rx_ninth_r <= rx_ninth_nxt;
         rx_prev_r <= serial_in_pin;
      end
   end

   sequence s_stop_seen;
      ce && rx_stop_hit;
   endsequence

   sequence s_no_ctrl_wr;
      !(wr_ctrl && ce);
   endsequence

   property p_mode_8bit;
      @(posedge pclk) disable iff (!presetn)
      (ce && ctrl_r.ren && !ctrl_r.mode9 && rx_half && !rx_start
         && rx_state_r == ASP_DATA && rx_cnt_r == `ASP_LAST_DATA) |=> rx_state_r == ASP_STOP;
   endproperty
   a_mode_8bit: assert property (p_mode_8bit)
      else $error("8-bit frame did not go to stop after eighth bit");

   property p_load_8bit;
      @(posedge pclk) disable iff (!presetn)
      (s_stop_seen ##0 (!ctrl_r.mode9 && rx_accept)) |=>
         (rx_buf_r == $past(rx_shift_r)) && (ctrl_r.rb8 == $past(serial_in_pin));
   endproperty
   a_load_8bit: assert property (p_load_8bit)
      else $error("8-bit load stored wrong data or stop bit");

   property p_tx_starts;
      @(posedge pclk) disable iff (!presetn)
      (ce && wr_data) |=> !serial_out_pin;
   endproperty
   a_tx_starts: assert property (p_tx_starts)
      else $error("write to data buffer did not start a frame");

   property p_ti_set;
      @(posedge pclk) disable iff (!presetn)
      (ce && tx_done) |=> ctrl_r.ti;
   endproperty
   a_ti_set: assert property (p_ti_set)
      else $error("transmit-done flag not set");

   property p_rx_disabled;
      @(posedge pclk) disable iff (!presetn)
      (ce && !ctrl_r.ren) |=> rx_state_r == ASP_IDLE;
   endproperty
   a_rx_disabled: assert property (p_rx_disabled)
      else $error("receiver active while disabled");

   property p_overrun_keep;
      @(posedge pclk) disable iff (!presetn)
      // A software write in the same cycle may legally change the ninth bit
      (s_stop_seen ##0 (ctrl_r.ri && !wr_ctrl)) |=> $stable(rx_buf_r) && $stable(ctrl_r.rb8);
   endproperty
   a_overrun_keep: assert property (p_overrun_keep)
      else $error("receive buffer overwritten on overrun");

   property p_filter_reject;
      @(posedge pclk) disable iff (!presetn)
      (s_stop_seen ##0 (ctrl_r.mce && ctrl_r.mode9 && !rx_ninth_r && !wr_ctrl))
         |=> $stable(rx_buf_r) && $stable(ctrl_r.ri);
   endproperty
   a_filter_reject: assert property (p_filter_reject)
      else $error("data frame passed the address filter");

   property p_ri_set;
      @(posedge pclk) disable iff (!presetn)
      (ce && rx_accept) |=> ctrl_r.ri ##1 (ctrl_r.ri || $past(wr_ctrl));
   endproperty
   a_ri_set: assert property (p_ri_set)
      else $error("receive-done flag not set on accepted frame");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      irq == (irq_enable && (ctrl_r.ti || ctrl_r.ri));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt request does not follow the done flags");

   property p_flags_hold;
      @(posedge pclk) disable iff (!presetn)
      s_no_ctrl_wr |=> !$fell(ctrl_r.ti) && !$fell(ctrl_r.ri);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("done flag cleared without a software write");

   property p_unused_bit;
      @(posedge pclk) disable iff (!presetn)
      rd_ctrl |-> prdata[`ASP_BIT_UNUSED];
   endproperty
   a_unused_bit: assert property (p_unused_bit)
      else $error("unused control bit did not read as one");

   property p_rx_resync;
      @(posedge pclk) disable iff (!presetn)
      (ce && rx_start) |=> rx_state_r == ASP_START ##1 !$rose(rx_half);
   endproperty
   a_rx_resync: assert property (p_rx_resync)
      else $error("start edge did not restart the receive timer");

   property p_data_read;
      @(posedge pclk) disable iff (!presetn)
      rd_data |-> prdata == {24'h00_0000, rx_buf_r};
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read did not return the receive buffer");
endmodule // asp_uart

// ### verification/asp_remote.sv
`timescale 1ns/1ps
module asp_remote #(
   parameter int BIT = 8
) (
   input wire logic pclk,
   input wire logic line_in,
   input wire logic nine,
   output logic line_out,
   output logic rx_vld,
   output logic [9:0] rx_frm
);
   logic [9:0] frm;

   initial begin
      line_out = 1'b1;
      rx_vld = 1'b0;
      rx_frm = 10'h000;
   end

   // One frame, LSB first; line returns high when done
   task automatic send(input logic [7:0] d, input logic n9, input logic b9, input logic stp);
      logic [10:0] f;
      int nb;
      f = n9 ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
      nb = n9 ? 11 : 10;
      @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         line_out <= f[i];
         repeat (BIT) @(posedge pclk);
      end
      line_out <= 1'b1;
   endtask

   // Mid-bit sampling keeps us clear of the port's edge jitter
   initial forever begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge pclk);
      if (line_in === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge pclk);
            frm[i] = line_in;
         end
         frm[8] = 1'b0;
         if (nine) begin
            repeat (BIT) @(posedge pclk);
            frm[8] = line_in;
         end
         repeat (BIT) @(posedge pclk);
         frm[9] = line_in;
         rx_frm <= frm;
         rx_vld <= 1'b1;
         @(posedge pclk);
         rx_vld <= 1'b0;
      end
   end
endmodule // asp_remote

// ### verification/asp_uart_tb_top.sv
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_uart_tb_top;
   import asp_pkg::*;
   localparam logic [7:0] RLD = 8'hfc;
   localparam int BIT = 2 * (256 - int'(RLD));
   localparam logic [11:0] A_CTRL = {`ASP_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_DATA = {`ASP_DATA_IDX, 2'b00};
   logic pclk, presetn, ce, psel, penable, pwrite, baud_run, baud_tick, irq_enable, nine;
   logic pready, pslverr, serial_in_pin, serial_out_pin, irq, rx_vld, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] baud_reload_value, last_d;
   logic [9:0] rx_frm;
   logic [9:0] txq[$];
   int miscompares, n_checks, seed, cyc;

   asp_uart #(.TW(8)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .baud_run(baud_run), .baud_tick(baud_tick),
      .baud_reload_value(baud_reload_value), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .irq_enable(irq_enable), .irq(irq));
   asp_remote #(.BIT(BIT)) remote_u (.pclk(pclk), .line_in(serial_out_pin), .nine(nine),
      .line_out(serial_in_pin), .rx_vld(rx_vld), .rx_frm(rx_frm));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(rd, {24'h0, exp}, what);
   endtask

   // Expected frame is queued before the write that launches it
   task tx(input logic n9, input logic b9);
      logic [7:0] d;
      int t0;
      int nb;
      d = 8'($random(seed));
      nb = n9 ? 10 : 9;
      apb(1'b1, A_CTRL, {24'h0, n9, 3'b001, b9, 3'b000});
      nine <= n9;
      txq.push_back({1'b1, n9 & b9, d});
      apb(1'b1, A_DATA, {24'h0, d});
      t0 = cyc;
      do apb(1'b0, A_CTRL, 32'h0); while (rd[1] !== 1'b1);
      check(32'((cyc - t0) >= nb * BIT && (cyc - t0) <= nb * BIT + 5), 1, "ti_time");
      repeat (2 * BIT) @(posedge pclk);
      apb(1'b0, A_CTRL, 32'h0);
      check(32'(rd[1]), 1, "ti_hold");
   endtask

   task rx(input logic [7:0] ctl, input logic b9, input logic stp, input logic take);
      logic [7:0] d;
      logic [7:0] expc;
      d = 8'($random(seed));
      apb(1'b1, A_CTRL, {24'h0, ctl});
      remote_u.send(d, ctl[7], b9, stp);
      repeat (BIT) @(posedge pclk);
      expc = ctl | 8'h40;
      if (take) begin
         expc[0] = 1'b1;
         expc[2] = ctl[7] ? b9 : stp;
         last_d = d;
      end
      rdc(A_CTRL, expc, "rx_ctrl");
      rdc(A_DATA, last_d, "rx_data");
   endtask

   always @(posedge pclk) begin
      if (rx_vld === 1'b1)
         check(32'(rx_frm), txq.size() > 0 ? 32'(txq.pop_front()) : 32'hx, "tx_frame");
   end

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      close_out;
   end

   initial begin
      seed = 32'hd113;
      cyc = 0;
      presetn = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      baud_run = 1'b1;
      baud_tick = 1'b1;
      baud_reload_value = RLD;
      irq_enable = 1'b0;
      nine = 1'b0;
      last_d = 8'h00;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_CTRL, 8'h40, "ctrl_reset");
      rdc(A_DATA, 8'h00, "data_reset");
      apb(1'b0, 12'h100, 32'h0);
      check(32'(err), 1, "unmapped_err");
      apb(1'b1, A_CTRL, 32'h000000bc);
      rdc(A_CTRL, 8'hfc, "ctrl_rw");
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         tx(1'b0, 1'b1);
         tx(1'b1, i[0]);
      end
      // Every launched frame must have reached the far side
      check(32'(txq.size()), 0, "tx_left");
      $display("test transmit done");
      rx(8'h10, 1'b0, 1'b1, 1'b1);
      irq_enable <= 1'b1;
      @(posedge pclk);
      @(posedge pclk);
      check(32'(irq), 1, "irq_on");
      irq_enable <= 1'b0;
      @(posedge pclk);
      @(posedge pclk);
      check(32'(irq), 0, "irq_off");
      rx(8'h11, 1'b0, 1'b1, 1'b0);
      rx(8'h30, 1'b0, 1'b0, 1'b0);
      rx(8'h10, 1'b0, 1'b0, 1'b1);
      rx(8'hb0, 1'b0, 1'b1, 1'b0);
      rx(8'hb0, 1'b1, 1'b0, 1'b1);
      rx(8'h90, 1'b0, 1'b1, 1'b1);
      rx(8'h00, 1'b0, 1'b1, 1'b0);
      $display("test receive done");
      close_out;
   end
endmodule // asp_uart_tb_top
